// ===== sim/hpa_mem_model.sv
`timescale 1ns/1ps
module hpa_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic [1:0]  i_be_n,
	input  wire logic [3:0]  i_delay,
	output logic             o_ack,
	output logic      [15:0] o_rdata
);
	logic [15:0] mem [0:255];
	logic [3:0]  cnt_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r   <= 4'h0;
			o_ack   <= 1'b0;
			o_rdata <= 16'h5A5A;
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'(i) ^ 16'hC3C3;
		end else begin
			o_ack   <= 1'b0;
			// Junk outside the ack cycle
			o_rdata <= ~o_rdata;
			cnt_r   <= 4'h0;
			if (i_req && !o_ack) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == i_delay) begin
					o_ack <= 1'b1;
					cnt_r <= 4'h0;
					if (!i_we)
						o_rdata <= mem[i_addr[7:0]];
					if (i_we && !i_be_n[0])
						mem[i_addr[7:0]][7:0] <= i_wdata[7:0];
					if (i_we && !i_be_n[1])
						mem[i_addr[7:0]][15:8] <= i_wdata[15:8];
				end
			end
		end
	end
endmodule : hpa_mem_model

// ===== sim/hpa_port_tb.sv
`timescale 1ns/1ps
module hpa_port_tb;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_mux_mode = 1'b1;
	logic        i_cs_n = 1'b1;
	logic        i_ds_first_n = 1'b1;
	logic        i_ds_second_n = 1'b1;
	logic        i_rnw = 1'b1;
	logic [1:0]  i_sel = 2'h0;
	logic [1:0]  i_be_n = 2'h0;
	logic [13:0] i_addr = 14'h0000;
	logic [15:0] i_hd = 16'h0000;
	logic        i_host_interrupt_out_set = 1'b0;
	logic [3:0]  mem_delay = 4'h0;
	logic        cs_mode = 1'b0;
	logic [15:0] o_hd;
	logic        o_hd_oe;
	logic        o_ready;
	logic        o_host_interrupt_out;
	logic        o_mem_req;
	logic        o_mem_we;
	logic [15:0] o_mem_addr;
	logic [15:0] o_mem_wdata;
	logic [1:0]  o_mem_be_n;
	logic        i_mem_ack;
	logic [15:0] i_mem_rdata;
	int          check_count = 0;
	int          fail_count = 0;
	realtime     t_pos = 0;

	hpa_port DUT (
		.i_clk, .i_rstn, .i_mux_mode, .i_cs_n, .i_ds_first_n,
		.i_ds_second_n, .i_rnw, .i_sel, .i_be_n, .i_addr, .i_hd,
		.o_hd, .o_hd_oe, .o_ready, .o_host_interrupt_out, .i_host_interrupt_out_set, .o_mem_req,
		.o_mem_we, .o_mem_addr, .o_mem_wdata, .o_mem_be_n, .i_mem_ack,
		.i_mem_rdata
	);

	hpa_mem_model mem (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_req   (o_mem_req),
		.i_we    (o_mem_we),
		.i_addr  (o_mem_addr),
		.i_wdata (o_mem_wdata),
		.i_be_n  (o_mem_be_n),
		.i_delay (mem_delay),
		.o_ack   (i_mem_ack),
		.o_rdata (i_mem_rdata)
	);

	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		t_pos = $realtime;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask : check

	always @(o_host_interrupt_out) begin
		if (i_rstn === 1'b1)
			check(16'($realtime == t_pos), 16'h0001, "host_interrupt_out off edge");
	end

	task automatic set_strobe(input logic v);
		if (cs_mode)
			i_cs_n = v;
		else
			i_ds_first_n = v;
	endtask : set_strobe

	task automatic host_acc(input logic rnw, input logic [1:0] sel,
		input logic [1:0] be_n, input logic [13:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output int lat);
		logic [15:0] prev;
		logic        oe_seen;
		lat = 0;
		oe_seen = 1'b0;
		prev = 16'h0000;
		@(negedge i_clk);
		// fields settle before the strobe, then held
		i_rnw = rnw;
		i_sel = sel;
		i_be_n = be_n;
		i_addr = a;
		i_hd = wd;
		if (!cs_mode)
			i_cs_n = 1'b0;
		@(negedge i_clk);
		set_strobe(1'b0);
		// low span, data held over rise
		if (!rnw)
			repeat (4) @(negedge i_clk);
		if (!rnw)
			set_strobe(1'b1);
		while (o_ready !== 1'b0 && lat < 6) begin
			@(negedge i_clk);
			lat++;
		end
		check(16'(o_ready), 16'h0000, "ready not dropped");
		while (o_ready !== 1'b1 && lat < 300) begin
			prev = o_hd;
			oe_seen = oe_seen | o_hd_oe;
			@(negedge i_clk);
			lat++;
		end
		rd = o_hd;
		if (rnw) begin
			check(prev, o_hd, "data after ready");
			check(16'(o_hd_oe), 16'h0001, "bus not driven");
			repeat (2) @(negedge i_clk);
			set_strobe(1'b1);
		end else
			check(16'(oe_seen), 16'h0000, "driven on write");
		@(negedge i_clk);
		if (!cs_mode)
			i_cs_n = 1'b1;
		// Released bus shows the inverted write data
		i_hd = ~wd;
		repeat (5) @(negedge i_clk);
		check(16'(o_hd_oe), 16'h0000, "bus not released");
		check(16'(o_ready), 16'h0001, "ready not idle");
	endtask : host_acc

	task automatic wr(input logic [1:0] sel, input logic [1:0] be_n,
		input logic [13:0] a, input logic [15:0] wd);
		logic [15:0] rd;
		int          lat;
		host_acc(1'b0, sel, be_n, a, wd, rd, lat);
		check(16'(lat >= 15), 16'h0001, "write ready early");
	endtask : wr

	task automatic rd_chk(input logic [1:0] sel, input logic [13:0] a,
		input logic [15:0] exp, input string msg, output int lat);
		logic [15:0] rd;
		host_acc(1'b1, sel, 2'h0, a, 16'h0000, rd, lat);
		check(rd, exp, msg);
	endtask : rd_chk

	task automatic test_autoinc();
		int lat;
		i_mux_mode = 1'b1;
		wr(hpa_pkg::SEL_ADDR, 2'h0, 14'h0, 16'h0010);
		wr(hpa_pkg::SEL_DATA_INC, 2'h2, 14'h0, 16'h0034);
		wr(hpa_pkg::SEL_DATA_INC, 2'h1, 14'h0, 16'h1200);
		wr(hpa_pkg::SEL_DATA_INC, 2'h0, 14'h0, 16'hBEEF);
		rd_chk(hpa_pkg::SEL_ADDR, 14'h0, 16'h0010, "base", lat);
		$display("test_autoinc done");
	endtask : test_autoinc

	task automatic test_mem_read();
		int lat;
		// Slow memory still answers inside the read minimum
		mem_delay = 4'h9;
		wr(hpa_pkg::SEL_ADDR, 2'h0, 14'h0, 16'h0010);
		rd_chk(hpa_pkg::SEL_DATA, 14'h0, 16'h1234, "lanes", lat);
		check(16'(lat >= 16), 16'h0001, "read early");
		mem_delay = 4'h0;
		rd_chk(hpa_pkg::SEL_DATA_INC, 14'h0, 16'h1234, "inc", lat);
		check(16'(lat >= 16), 16'h0001, "read early");
		rd_chk(hpa_pkg::SEL_DATA, 14'h0, 16'hBEEF, "next", lat);
		rd_chk(hpa_pkg::SEL_ADDR, 14'h0, 16'h0010, "base", lat);
		$display("test_mem_read done");
	endtask : test_mem_read

	task automatic test_ctrl();
		int lat;
		i_mux_mode = 1'b0;
		@(negedge i_clk);
		i_host_interrupt_out_set = 1'b1;
		@(negedge i_clk);
		i_host_interrupt_out_set = 1'b0;
		repeat (3) @(negedge i_clk);
		check(16'(o_host_interrupt_out), 16'h0001, "host_interrupt_out not set");
		rd_chk(2'h2, 14'h0011, 16'h0001, "ctrl", lat);
		rd_chk(2'h1, 14'h0011, 16'hBEEF, "direct", lat);
		wr(2'h0, 2'h0, 14'h0011, 16'h0002);
		check(16'(o_host_interrupt_out), 16'h0000, "host_interrupt_out not cleared");
		rd_chk(2'h3, 14'h0011, 16'hBEEF, "ctrl hit mem", lat);
		$display("test_ctrl done");
	endtask : test_ctrl

	task automatic test_cs_strobe();
		int lat;
		cs_mode = 1'b1;
		i_ds_first_n = 1'b0;
		i_ds_second_n = 1'b0;
		wr(2'h3, 2'h0, 14'h0020, 16'hA55A);
		rd_chk(2'h3, 14'h0020, 16'hA55A, "cs strobe", lat);
		i_ds_first_n = 1'b1;
		i_ds_second_n = 1'b1;
		cs_mode = 1'b0;
		$display("test_cs_strobe done");
	endtask : test_cs_strobe

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20) @(negedge i_clk);
		i_rstn = 1'b1;
		repeat (4) @(negedge i_clk);
		check(16'(o_ready), 16'h0001, "idle ready");
		test_autoinc();
		test_mem_read();
		test_ctrl();
		test_cs_strobe();
		complete_run();
	end

	// 16 accesses of under 60 cycles; over twelve times margin
	initial begin
		#120000;
		fail_count++;
		complete_run();
	end
endmodule : hpa_port_tb

// ===== src/hpa_fifo.sv
`timescale 1ns/1ps
module hpa_fifo #(
	parameter int W     = 34,
	parameter int DEPTH = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic      [W-1:0] o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} hpa_fifo_s;

	hpa_fifo_s      r_r;
	hpa_fifo_s      r_nxt;
	logic [W-1:0]   mem_r [DEPTH];
	logic           push;
	logic           pop;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
			$error("hpa_fifo: depth must be a power of two >= 2");
		end
	end

	assign o_ready = (r_r.cnt != (AW+1)'(DEPTH));
	assign o_valid = (r_r.cnt != '0);
	assign o_data  = mem_r[r_r.rp];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb begin
		r_nxt = r_r;
		if (push) begin
			r_nxt.wp = r_r.wp + AW'(1);
		end
		if (pop) begin
			r_nxt.rp = r_r.rp + AW'(1);
		end
		r_nxt.cnt = r_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Storage needs no reset; only the pointers define content
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[r_r.wp] <= i_data;
		end
	end
endmodule : hpa_fifo

// ===== src/hpa_pkg.sv
package hpa_pkg;
	// Access-type selector codes
	localparam logic [1:0] SEL_CTRL     = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDR     = 2'h2;
	localparam logic [1:0] SEL_DATA     = 2'h3;

	// Port control register bit positions
	localparam int CTRL_HOST_INTERRUPT_OUT_BIT = 0;
	localparam int CTRL_CLR_BIT  = 1;

	// Reset values
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// Minimum memory latency, in CPU clock periods
	localparam int CLK_PERIOD_NS = 10;
	localparam int CPU_PERIOD_NS = 10;
	localparam int MEM_LAT_P     = 14;
	localparam int MEM_LAT_CYC   =
		(MEM_LAT_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Pin synchroniser depth and FIFO depth
	localparam int SYNC_STAGES = 2;
	localparam int FIFO_DEPTH  = 8;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_RD_WAIT = 2'b01,
		ST_RD_DONE = 2'b10,
		ST_WR_WAIT = 2'b11
	} hpa_state_e;

	typedef enum logic [1:0] {
		T_CTRL = 2'b00,
		T_DINC = 2'b01,
		T_ADDR = 2'b10,
		T_DATA = 2'b11
	} hpa_target_e;
endpackage : hpa_pkg

// ===== src/hpa_port.sv
// Operation
// - Non-multiplexed, selector bit zero hits control register
// - Strobes tied active, chip select strobes
// - Ready output always shows internal ready
// - Autoincrement advances address, reads return base
// - Byte accesses increment only after upper byte
// - Reads drop ready after strobe falls
// - Reads raise ready after data driven
// - Writes drop ready, hold fourteen periods
// - Memory read data no sooner than fourteen
// - Extra latency from competing memory traffic
// - Host interrupt changes on clock rising edge
// - Write data captured on strobe rise
// - Data bus driven only during reads
`timescale 1ns/1ps
module hpa_port #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	input  wire logic          i_clk,
	input  wire logic          i_rstn,
	input  wire logic          i_mux_mode,
	input  wire logic          i_cs_n,
	input  wire logic          i_ds_first_n,
	input  wire logic          i_ds_second_n,
	input  wire logic          i_rnw,
	input  wire logic [1:0]    i_sel,
	input  wire logic [1:0]    i_be_n,
	input  wire logic [13:0]   i_addr,
	input  wire logic [DW-1:0] i_hd,
	output logic      [DW-1:0] o_hd,
	output logic               o_hd_oe,
	output logic               o_ready,
	output logic               o_host_interrupt_out,
	input  wire logic          i_host_interrupt_out_set,
	output logic               o_mem_req,
	output logic               o_mem_we,
	output logic      [AW-1:0] o_mem_addr,
	output logic      [DW-1:0] o_mem_wdata,
	output logic      [1:0]    o_mem_be_n,
	input  wire logic          i_mem_ack,
	input  wire logic [DW-1:0] i_mem_rdata
);
	localparam int PW = 1 + 1 + 1 + 1 + 1 + 2 + 2 + 14 + DW;
	localparam int FW = AW + DW + 2;
	localparam int LAT_CNT = hpa_pkg::MEM_LAT_CYC;
	initial begin
		if (AW < 14 || DW != 16) begin
			$error("hpa_port: need AW >= 14 and DW == 16");
		end
	end
	typedef struct packed {
		hpa_pkg::hpa_state_e  st;
		logic [4:0]           cnt;
		logic                 rdy;
		logic [DW-1:0]        hd;
		logic                 oe;
		logic [AW-1:0]        base;
		logic [AW-1:0]        cur;
		logic                 host_interrupt_out;
		logic                 strb_d;
		hpa_pkg::hpa_target_e tgt;
		logic [1:0]           be_n;
		logic [AW-1:0]        acc_addr;
		logic [DW-1:0]        rbuf;
		logic                 issued;
		logic                 got;
		logic                 push_pend;
		logic [DW-1:0]        wd;
		logic                 mreq;
		logic                 mwe;
		logic [AW-1:0]        maddr;
		logic [DW-1:0]        mwd;
		logic [1:0]           mbe_n;
	} hpa_port_s;
	hpa_port_s     r_r;
	hpa_port_s     r_nxt;
	logic [PW-1:0] pins_s;
	logic          s_mux;
	logic          s_cs;
	logic          s_ds1;
	logic          s_ds2;
	logic          s_rnw;
	logic [1:0]    s_sel;
	logic [1:0]    s_be_n;
	logic [13:0]   s_addr;
	logic [DW-1:0] s_hd;
	logic          strb;
	logic          fall_ev;
	logic          rise_ev;
	logic          f_in_valid;
	logic          f_in_ready;
	logic [FW-1:0] f_in_data;
	logic          f_out_valid;
	logic          f_out_ready;
	logic [FW-1:0] f_out_data;
	function automatic hpa_pkg::hpa_target_e decode_target(
		input logic mux, input logic [1:0] sel);
		hpa_pkg::hpa_target_e t;
		t = hpa_pkg::T_CTRL;
		if (!mux) begin
			t = sel[0] ? hpa_pkg::T_DATA : hpa_pkg::T_CTRL;
		end else begin
			case (sel)
				hpa_pkg::SEL_CTRL:     t = hpa_pkg::T_CTRL;
				hpa_pkg::SEL_DATA_INC: t = hpa_pkg::T_DINC;
				hpa_pkg::SEL_ADDR:     t = hpa_pkg::T_ADDR;
				default:               t = hpa_pkg::T_DATA;
			endcase
		end
		return t;
	endfunction : decode_target
	hpa_sync #(
		.W (PW)
	) u_sync (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_d    ({i_mux_mode, ~i_cs_n, ~i_ds_first_n, ~i_ds_second_n,
		          i_rnw, i_sel, i_be_n, i_addr, i_hd}),
		.o_q    (pins_s)
	);
	// Strobes enter inverted: a cleared synchroniser then reads idle
	assign {s_mux, s_cs, s_ds1, s_ds2, s_rnw, s_sel, s_be_n,
		s_addr, s_hd} = pins_s;
	assign strb    = s_cs && (s_ds1 || s_ds2);
	assign fall_ev = strb && !r_r.strb_d;
	assign rise_ev = !strb && r_r.strb_d;
	assign f_in_valid  = r_r.push_pend;
	assign f_in_data   = {r_r.acc_addr, r_r.wd, r_r.be_n};
	assign f_out_ready = !r_r.mreq;
	hpa_fifo #(
		.W     (FW),
		.DEPTH (hpa_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_valid (f_in_valid),
		.o_ready (f_in_ready),
		.i_data  (f_in_data),
		.o_valid (f_out_valid),
		.i_ready (f_out_ready),
		.o_data  (f_out_data)
	);
	always_comb begin
		r_nxt        = r_r;
		r_nxt.strb_d = strb;
		if (r_r.cnt != 5'h1F) begin
			r_nxt.cnt = r_r.cnt + 5'h01;
		end
		// Memory port: posted writes drain first, then a read
		if (r_r.mreq) begin
			if (i_mem_ack) begin
				r_nxt.mreq = 1'b0;
				if (!r_r.mwe) begin
					r_nxt.rbuf = i_mem_rdata;
					r_nxt.got  = 1'b1;
				end
			end
		end else if (f_out_valid) begin
			r_nxt.mreq  = 1'b1;
			r_nxt.mwe   = 1'b1;
			{r_nxt.maddr, r_nxt.mwd, r_nxt.mbe_n} = f_out_data;
		end else if (r_r.st == hpa_pkg::ST_RD_WAIT && !r_r.issued &&
			!r_r.push_pend) begin
			r_nxt.mreq   = 1'b1;
			r_nxt.mwe    = 1'b0;
			r_nxt.maddr  = r_r.acc_addr;
			r_nxt.mbe_n  = r_r.be_n;
			r_nxt.issued = 1'b1;
		end
		if (f_in_valid && f_in_ready) begin
			r_nxt.push_pend = 1'b0;
		end
		case (r_r.st)
			hpa_pkg::ST_IDLE: begin
				if (fall_ev) begin
					r_nxt.tgt  = decode_target(s_mux, s_sel);
					r_nxt.be_n = s_be_n;
					r_nxt.cnt  = 5'h00;
					r_nxt.acc_addr = s_mux ? r_r.cur : AW'(s_addr);
					if (s_rnw) begin
						r_nxt.rdy    = 1'b0;
						// drive bus while read strobe low
						r_nxt.oe     = 1'b1;
						r_nxt.issued = 1'b0;
						r_nxt.got    = 1'b0;
						r_nxt.st     = hpa_pkg::ST_RD_WAIT;
					end
				end else if (rise_ev && !s_rnw) begin
					// write data taken at strobe rise
					r_nxt.wd  = s_hd;
					r_nxt.cnt = 5'h00;
					r_nxt.rdy = 1'b0;
					r_nxt.st  = hpa_pkg::ST_WR_WAIT;
					case (r_r.tgt)
						hpa_pkg::T_CTRL: begin
							if (s_hd[hpa_pkg::CTRL_CLR_BIT]) begin
								r_nxt.host_interrupt_out = 1'b0;
							end
						end
						hpa_pkg::T_ADDR: begin
							r_nxt.base = AW'(s_hd);
							r_nxt.cur  = AW'(s_hd);
						end
						default: begin
							r_nxt.push_pend = 1'b1;
							if (r_r.tgt == hpa_pkg::T_DINC && !r_r.be_n[1]) begin
								r_nxt.cur = r_r.cur + AW'(1);
							end
						end
					endcase
				end
			end
			hpa_pkg::ST_RD_WAIT: begin
				case (r_r.tgt)
					hpa_pkg::T_CTRL: begin
						r_nxt.hd = DW'({r_r.host_interrupt_out, 1'b0} >> 1);
						r_nxt.st = hpa_pkg::ST_RD_DONE;
					end
					hpa_pkg::T_ADDR: begin
						r_nxt.hd = DW'(r_r.base);
						r_nxt.st = hpa_pkg::ST_RD_DONE;
					end
					default: begin
						// a busy memory port only adds wait
						if (r_r.got && r_r.cnt >= 5'(LAT_CNT)) begin
							r_nxt.hd = r_r.rbuf;
							r_nxt.st = hpa_pkg::ST_RD_DONE;
						end
					end
				endcase
			end
			hpa_pkg::ST_RD_DONE: begin
				// ready rises once data already on bus
				r_nxt.rdy = 1'b1;
				if (!strb) begin
					r_nxt.oe = 1'b0;
					r_nxt.st = hpa_pkg::ST_IDLE;
					if (r_r.tgt == hpa_pkg::T_DINC && !r_r.be_n[1]) begin
						r_nxt.cur = r_r.cur + AW'(1);
					end
				end
			end
			hpa_pkg::ST_WR_WAIT: begin
				if (!r_r.push_pend && r_r.cnt >= 5'(LAT_CNT - 1)) begin
					r_nxt.rdy = 1'b1;
					r_nxt.st  = hpa_pkg::ST_IDLE;
				end
			end
			default: begin
				r_nxt.st = hpa_pkg::ST_IDLE;
			end
		endcase
		// interrupt set wins over a host clear
		if (i_host_interrupt_out_set) begin
			r_nxt.host_interrupt_out = 1'b1;
		end
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r      <= '0;
			r_r.rdy  <= 1'b1;
			r_r.st   <= hpa_pkg::ST_IDLE;
			r_r.base <= AW'(hpa_pkg::ADDR_RST);
			r_r.cur  <= AW'(hpa_pkg::ADDR_RST);
			r_r.hd   <= hpa_pkg::DATA_RST;
		end else begin
			r_r <= r_nxt;
		end
	end
	// ready pin is the ready flop itself
	assign o_ready     = r_r.rdy;
	assign o_hd        = r_r.hd;
	assign o_hd_oe     = r_r.oe;
	assign o_host_interrupt_out      = r_r.host_interrupt_out;
	assign o_mem_req   = r_r.mreq;
	assign o_mem_we    = r_r.mwe;
	assign o_mem_addr  = r_r.maddr;
	assign o_mem_wdata = r_r.mwd;
	assign o_mem_be_n  = r_r.mbe_n;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	ctrl_route_a: assert property (
		(r_r.st == hpa_pkg::ST_IDLE && fall_ev && !s_mux && !s_sel[0])
		|=> r_r.tgt == hpa_pkg::T_CTRL)
		else $error("control access not routed to control register");
	rd_rdy_low_a: assert property (
		(r_r.st == hpa_pkg::ST_IDLE && fall_ev && s_rnw)
		|=> !o_ready && o_hd_oe)
		else $error("ready not dropped on read strobe");
	rd_data_first_a: assert property (
		($rose(o_ready) && $past(r_r.st) == hpa_pkg::ST_RD_DONE)
		|-> o_hd_oe && $past(o_hd_oe) && $past(o_hd) == o_hd)
		else $error("ready rose before read data driven");
	wr_rdy_hold_a: assert property (
		(r_r.st == hpa_pkg::ST_IDLE && rise_ev && !s_rnw)
		|=> !o_ready [*8] ##1 !o_ready)
		else $error("write ready released too early");
	wr_rdy_min_a: assert property (
		($rose(o_ready) && $past(r_r.st) == hpa_pkg::ST_WR_WAIT)
		|-> $past(r_r.cnt) >= LAT_CNT - 1)
		else $error("write ready below fourteen periods");
	mem_lat_a: assert property (
		(r_r.st == hpa_pkg::ST_RD_DONE &&
		 $past(r_r.st) == hpa_pkg::ST_RD_WAIT && r_r.tgt[0])
		|-> $past(r_r.cnt) >= LAT_CNT)
		else $error("memory read data too early");
	hd_drive_a: assert property (
		$rose(o_hd_oe) |-> $past(fall_ev) && $past(s_rnw))
		else $error("data bus driven outside a read");
	host_interrupt_out_set_a: assert property (
		i_host_interrupt_out_set |=> o_host_interrupt_out)
		else $error("interrupt set lost");
	byte_inc_a: assert property (
		(r_r.st == hpa_pkg::ST_IDLE && rise_ev && !s_rnw &&
		 r_r.tgt == hpa_pkg::T_DINC && r_r.be_n[1])
		|=> $stable(r_r.cur))
		else $error("address advanced after lower byte");
	rd_mem_c: cover property (
		r_r.st == hpa_pkg::ST_RD_WAIT && r_r.tgt[0] ##[1:40]
		r_r.st == hpa_pkg::ST_RD_DONE);
	wr_mem_c: cover property (
		r_r.push_pend ##[1:40] (o_mem_req && o_mem_we && i_mem_ack));
	rd_reg_c: cover property (
		r_r.st == hpa_pkg::ST_RD_DONE && r_r.tgt == hpa_pkg::T_ADDR);
endmodule : hpa_port

// ===== src/hpa_sync.sv
`timescale 1ns/1ps
module hpa_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hpa_sync_s;

	hpa_sync_s r_r;
	hpa_sync_s r_nxt;

	initial begin
		if (W < 1) begin
			$error("hpa_sync: width must be positive");
		end
	end

	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = i_d;
		r_nxt.s2 = r_r.s1;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_q = r_r.s2;
endmodule : hpa_sync
